// *** inc/lvpw_defines.vh ***
`ifndef LVPW_DEFINES_VH
`define LVPW_DEFINES_VH
// Register byte offsets.
`define LVPW_OFS_PWR_A 8'h00
`define LVPW_OFS_PWR_B 8'h04
`define LVPW_OFS_RTI_CTRL 8'h08
`define LVPW_OFS_CAUSE 8'h0C
`define LVPW_OFS_IRQ_STAT 8'h10
`define LVPW_OFS_IRQ_MASK 8'h14
`define LVPW_OFS_MODE 8'h18
// Power management control A fields.
`define LVPW_A_DET_EN 0
`define LVPW_A_KEEP 1
`define LVPW_A_RST_EN 2
`define LVPW_A_IRQ_EN 3
`define LVPW_A_OSC_KEEP 4
`define LVPW_A_OSC_RANGE 5
`define LVPW_A_RESET 6'h05
// Power management control B fields.
`define LVPW_B_TRIP 0
`define LVPW_B_WTRIP 1
`define LVPW_B_WACK 6
`define LVPW_B_WFLAG 7
// Periodic timer control fields.
`define LVPW_T_SEL_LO 0
`define LVPW_T_SEL_HI 2
`define LVPW_T_IRQ_EN 4
`define LVPW_T_SRC_INT 5
`define LVPW_T_ACK 6
`define LVPW_T_FLAG 7
// Reset cause and interrupt status bits.
`define LVPW_C_LOWV 0
`define LVPW_C_POR 1
`define LVPW_I_LOWV 0
`define LVPW_I_TMR 1
// Requested mode codes.
`define LVPW_M_RUN 3'h0
`define LVPW_M_WAIT 3'h1
`define LVPW_M_STOP1 3'h2
`define LVPW_M_STOP2 3'h3
`define LVPW_M_STOP3 3'h4
`define LVPW_M_REFUSED 4
// Timer terminal counts for select values one to seven; each period is one source clock tick longer than its count.
`define LVPW_PER_1 10'h007
`define LVPW_PER_2 10'h01F
`define LVPW_PER_3 10'h03F
`define LVPW_PER_4 10'h07F
`define LVPW_PER_5 10'h0FF
`define LVPW_PER_6 10'h1FF
`define LVPW_PER_7 10'h3FF
`endif

// *** hdl/lvpw_top.v ***
`timescale 1ns/1ps
`include "lvpw_defines.vh"
`default_nettype none
module lvpw_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire supply_below_por,
  input wire supply_below_low,
  input wire supply_below_high,
  input wire warn_below_low,
  input wire warn_below_high,
  input wire ext_reference_clock,
  input wire internal_timer_clock,
  input wire wake_request,
  output wire system_reset,
  output wire detector_on,
  output wire irq,
  output wire [4:0] power_mode
);
  // Reset hold states.
  localparam [2:0] ST_RUN = 3'b001;
  localparam [2:0] ST_POR = 3'b010;
  localparam [2:0] ST_LVR = 3'b100;
  // Power mode states.
  localparam [4:0] PM_RUN = 5'b00001;
  localparam [4:0] PM_WAIT = 5'b00010;
  localparam [4:0] PM_STOP1 = 5'b00100;
  localparam [4:0] PM_STOP2 = 5'b01000;
  localparam [4:0] PM_STOP3 = 5'b10000;

  reg [2:0] rst_st_r;
  reg [2:0] rst_st_nxt;
  reg [4:0] mode_r;
  reg [4:0] mode_nxt;
  reg [5:0] ctrl_a_r;
  reg [1:0] ctrl_b_r;
  reg warn_flag_r;
  reg [2:0] period_sel_r;
  reg tmr_irq_en_r;
  reg tmr_src_int_r;
  reg tmr_flag_r;
  reg lowv_flag_r;
  reg [1:0] cause_r;
  reg [1:0] irq_mask_r;
  reg refused_r;
  reg [9:0] tmr_cnt_r;
  reg ext_prev_r;
  reg int_prev_r;
  reg [31:0] prdata_r;
  reg [31:0] rd_val;
  reg addr_ok;
  reg [9:0] period_max;

  wire wr_en;
  wire rd_setup;
  wire in_stop;
  wire lowv_det;
  wire above_trip;
  wire warn_det;
  wire ext_tick;
  wire int_tick;
  wire src_tick;
  wire tmr_run;
  wire tmr_wrap;
  wire wr_a;
  wire wr_b;
  wire wr_t;
  wire wr_stat;
  wire wr_mask;
  wire wr_mode;
  wire lowv_set;
  wire tmr_set;
  wire lowv_clr;
  wire tmr_clr;
  wire warn_clr;
  wire stop12_blocked;
  wire [2:0] mode_req;
  wire tmr_irq_src;

  // The slave answers with no wait state; read data is captured in the setup cycle.
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = prdata_r;

  // Address decode for the error answer; the write strobes compare the address on their own.
  always @* begin
    if (paddr == `LVPW_OFS_PWR_A) begin
      addr_ok = 1'b1;
    end else if (paddr == `LVPW_OFS_PWR_B) begin
      addr_ok = 1'b1;
    end else if (paddr == `LVPW_OFS_RTI_CTRL) begin
      addr_ok = 1'b1;
    end else if (paddr == `LVPW_OFS_CAUSE) begin
      addr_ok = 1'b1;
    end else if (paddr == `LVPW_OFS_IRQ_STAT) begin
      addr_ok = 1'b1;
    end else if (paddr == `LVPW_OFS_IRQ_MASK) begin
      addr_ok = 1'b1;
    end else if (paddr == `LVPW_OFS_MODE) begin
      addr_ok = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end

  assign wr_a = wr_en & (paddr == `LVPW_OFS_PWR_A);
  assign wr_b = wr_en & (paddr == `LVPW_OFS_PWR_B);
  assign wr_t = wr_en & (paddr == `LVPW_OFS_RTI_CTRL);
  assign wr_stat = wr_en & (paddr == `LVPW_OFS_IRQ_STAT);
  assign wr_mask = wr_en & (paddr == `LVPW_OFS_IRQ_MASK);
  assign wr_mode = wr_en & (paddr == `LVPW_OFS_MODE);
  assign mode_req = pwdata[2:0];

  // Detector gating: a stop mode turns it off unless keep-in-stop is set.
  assign in_stop = (mode_r == PM_STOP1) | (mode_r == PM_STOP2) | (mode_r == PM_STOP3);
  assign detector_on = ctrl_a_r[`LVPW_A_DET_EN] & (~in_stop | ctrl_a_r[`LVPW_A_KEEP]);
  assign lowv_det = detector_on & (ctrl_b_r[`LVPW_B_TRIP] ? supply_below_high : supply_below_low);
  assign above_trip = ctrl_b_r[`LVPW_B_TRIP] ? ~supply_below_high : ~supply_below_low;
  assign warn_det = ctrl_b_r[`LVPW_B_WTRIP] ? warn_below_high : warn_below_low;
  assign stop12_blocked = ctrl_a_r[`LVPW_A_DET_EN] & ctrl_a_r[`LVPW_A_KEEP];

  // The interrupt path is used only when reset on low voltage is off.
  assign lowv_set = lowv_det & ctrl_a_r[`LVPW_A_IRQ_EN] & ~ctrl_a_r[`LVPW_A_RST_EN];
  assign lowv_clr = wr_stat & pwdata[`LVPW_I_LOWV];

  // Reset hold sequencer; the power-on path always checks the low threshold.
  always @* begin
    rst_st_nxt = rst_st_r;
    case (rst_st_r)
      ST_RUN: begin
        if (supply_below_por) begin
          rst_st_nxt = ST_POR;
        end else if (lowv_det & ctrl_a_r[`LVPW_A_RST_EN]) begin
          rst_st_nxt = ST_LVR;
        end
      end
      ST_POR: begin
        if (~supply_below_por & ~supply_below_low) begin
          rst_st_nxt = ST_RUN;
        end
      end
      ST_LVR: begin
        if (supply_below_por) begin
          rst_st_nxt = ST_POR;
        end else if (above_trip) begin
          rst_st_nxt = ST_RUN;
        end
      end
      default: begin
        rst_st_nxt = ST_POR;
      end
    endcase
  end

  // A system reset is held for every cycle the sequencer is not running.
  assign system_reset = ~rst_st_r[0];

  // Power mode: stop1 and stop2 are refused while the detector is kept on.
  always @* begin
    mode_nxt = mode_r;
    if (~rst_st_r[0]) begin
      mode_nxt = PM_RUN;
    end else if (mode_r != PM_RUN) begin
      if (irq | wake_request) begin
        mode_nxt = PM_RUN;
      end
    end else if (wr_mode) begin
      case (mode_req)
        `LVPW_M_WAIT: begin
          mode_nxt = PM_WAIT;
        end
        `LVPW_M_STOP1: begin
          mode_nxt = stop12_blocked ? PM_RUN : PM_STOP1;
        end
        `LVPW_M_STOP2: begin
          mode_nxt = stop12_blocked ? PM_RUN : PM_STOP2;
        end
        `LVPW_M_STOP3: begin
          mode_nxt = PM_STOP3;
        end
        default: begin
          mode_nxt = PM_RUN;
        end
      endcase
    end
  end
  assign power_mode = mode_r;

  // Timer source by mode: external in run and wait, internal in stop2, either in stop3.
  assign ext_tick = ext_reference_clock & ~ext_prev_r;
  assign int_tick = internal_timer_clock & ~int_prev_r;
  assign src_tick = ((mode_r == PM_RUN) | (mode_r == PM_WAIT)) ? ext_tick :
                    (mode_r == PM_STOP2) ? int_tick :
                    (mode_r == PM_STOP3) ? (tmr_src_int_r ? int_tick : ext_tick) :
                    1'b0;
  // A zero period select gates the source clock off entirely.
  assign tmr_run = (period_sel_r != 3'h0) & rst_st_r[0];
  assign tmr_wrap = tmr_run & src_tick & (tmr_cnt_r == period_max);

  // Period table indexed by the select field.
  always @* begin
    case (period_sel_r)
      3'h1: period_max = `LVPW_PER_1;
      3'h2: period_max = `LVPW_PER_2;
      3'h3: period_max = `LVPW_PER_3;
      3'h4: period_max = `LVPW_PER_4;
      3'h5: period_max = `LVPW_PER_5;
      3'h6: period_max = `LVPW_PER_6;
      3'h7: period_max = `LVPW_PER_7;
      default: period_max = 10'h000;
    endcase
  end

  assign tmr_set = tmr_wrap;
  assign tmr_clr = (wr_t & pwdata[`LVPW_T_ACK]) | (wr_stat & pwdata[`LVPW_I_TMR]);
  assign warn_clr = wr_b & pwdata[`LVPW_B_WACK];
  assign tmr_irq_src = tmr_flag_r & tmr_irq_en_r;

  // One level interrupt from the masked sticky bits; the warning flag never joins it.
  assign irq = (lowv_flag_r & irq_mask_r[`LVPW_I_LOWV]) | (tmr_irq_src & irq_mask_r[`LVPW_I_TMR]);

  // Sequencer, mode and edge history.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_st_r <= ST_POR;
      mode_r <= PM_RUN;
      ext_prev_r <= 1'b0;
      int_prev_r <= 1'b0;
    end else begin
      rst_st_r <= rst_st_nxt;
      mode_r <= mode_nxt;
      ext_prev_r <= ext_reference_clock;
      int_prev_r <= internal_timer_clock;
    end
  end

  // Reset cause bits: power-on sets both, a low-voltage reset leaves the power-on bit alone.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_r <= 2'h3;
    end else if ((rst_st_r == ST_POR) & (rst_st_nxt == ST_RUN)) begin
      cause_r <= 2'h3;
    end else if ((rst_st_r == ST_LVR) & (rst_st_nxt == ST_RUN)) begin
      cause_r[`LVPW_C_LOWV] <= 1'b1;
    end
  end

  // Control registers return to defaults while the system reset is held.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_r <= `LVPW_A_RESET;
      ctrl_b_r <= 2'h0;
      period_sel_r <= 3'h0;
      tmr_irq_en_r <= 1'b0;
      tmr_src_int_r <= 1'b0;
      irq_mask_r <= 2'h0;
    end else if (~rst_st_r[0]) begin
      ctrl_a_r <= `LVPW_A_RESET;
      ctrl_b_r <= 2'h0;
      period_sel_r <= 3'h0;
      tmr_irq_en_r <= 1'b0;
      tmr_src_int_r <= 1'b0;
      irq_mask_r <= 2'h0;
    end else begin
      if (wr_a) begin
        ctrl_a_r <= pwdata[5:0];
      end
      if (wr_b) begin
        ctrl_b_r <= pwdata[1:0];
      end
      if (wr_t) begin
        period_sel_r <= pwdata[`LVPW_T_SEL_HI:`LVPW_T_SEL_LO];
        tmr_irq_en_r <= pwdata[`LVPW_T_IRQ_EN];
        tmr_src_int_r <= pwdata[`LVPW_T_SRC_INT];
      end
      if (wr_mask) begin
        irq_mask_r <= pwdata[1:0];
      end
    end
  end

  // Sticky flags; a set in the same cycle as a clear wins.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lowv_flag_r <= 1'b0;
      tmr_flag_r <= 1'b0;
      warn_flag_r <= 1'b0;
      refused_r <= 1'b0;
    end else if (~rst_st_r[0]) begin
      lowv_flag_r <= 1'b0;
      tmr_flag_r <= 1'b0;
      warn_flag_r <= 1'b0;
      refused_r <= 1'b0;
    end else begin
      lowv_flag_r <= lowv_set | (lowv_flag_r & ~lowv_clr);
      tmr_flag_r <= tmr_set | (tmr_flag_r & ~tmr_clr);
      warn_flag_r <= warn_det | (warn_flag_r & ~warn_clr);
      if (wr_mode & (mode_r == PM_RUN)) begin
        refused_r <= stop12_blocked & ((mode_req == `LVPW_M_STOP1) | (mode_req == `LVPW_M_STOP2));
      end
    end
  end

  // Period counter clears whenever the timer is off so a new period starts clean.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_cnt_r <= 10'h000;
    end else if (~tmr_run | (wr_t & (pwdata[2:0] != period_sel_r))) begin
      tmr_cnt_r <= 10'h000;
    end else if (tmr_wrap) begin
      tmr_cnt_r <= 10'h000;
    end else if (src_tick) begin
      tmr_cnt_r <= tmr_cnt_r + 10'h001;
    end
  end

  // Read multiplexer; write-only acknowledge bits read as zero.
  always @* begin
    rd_val = 32'h00000000;
    if (paddr == `LVPW_OFS_PWR_A) begin
      rd_val[5:0] = ctrl_a_r;
    end else if (paddr == `LVPW_OFS_PWR_B) begin
      rd_val[1:0] = ctrl_b_r;
      rd_val[`LVPW_B_WFLAG] = warn_flag_r;
    end else if (paddr == `LVPW_OFS_RTI_CTRL) begin
      rd_val[2:0] = period_sel_r;
      rd_val[`LVPW_T_IRQ_EN] = tmr_irq_en_r;
      rd_val[`LVPW_T_SRC_INT] = tmr_src_int_r;
      rd_val[`LVPW_T_FLAG] = tmr_flag_r;
    end else if (paddr == `LVPW_OFS_CAUSE) begin
      rd_val[1:0] = cause_r;
    end else if (paddr == `LVPW_OFS_IRQ_STAT) begin
      rd_val[`LVPW_I_LOWV] = lowv_flag_r;
      rd_val[`LVPW_I_TMR] = tmr_flag_r;
    end else if (paddr == `LVPW_OFS_IRQ_MASK) begin
      rd_val[1:0] = irq_mask_r;
    end else if (paddr == `LVPW_OFS_MODE) begin
      rd_val[`LVPW_M_REFUSED] = refused_r;
      rd_val[9:5] = mode_r;
    end
  end

  // Read data is registered so it stands stable through the access phase.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (rd_setup) begin
      prdata_r <= rd_val;
    end
  end
endmodule // lvpw_top
`default_nettype wire

// *** testbench/lvpw_top_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module lvpw_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic supply_below_por,
  input wire logic supply_below_low,
  input wire logic system_reset,
  input wire logic detector_on,
  input wire logic irq,
  input wire logic [4:0] power_mode
);
  // One clock domain, so the clock and the reset are given once for all checks.
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_POR_HOLD: assert property (supply_below_por |=> system_reset)
    else $error("power-on level did not start the reset hold");
  AST_HOLD_LOW: assert property (system_reset && supply_below_low |=> system_reset)
    else $error("reset hold ended while supply still low");
  AST_HOLD_EXIT: assert property (system_reset && !supply_below_por && !supply_below_low |=> !system_reset)
    else $error("reset hold did not end with good supply");
  // The first hold cycle may still show flags set before the hold began.
  AST_HOLD_NOIRQ: assert property (system_reset && $past(system_reset) |-> !irq)
    else $error("interrupt raised during reset hold");
  // The detector must stay armed through the hold, though the release reads the supply levels directly, not the detector.
  AST_HOLD_DETON: assert property (system_reset && $past(system_reset) |-> detector_on)
    else $error("detector off during reset hold");
  AST_STOP_NODET: assert property (power_mode[2] || power_mode[3] |-> !detector_on)
    else $error("detector on in stop1 or stop2");
  AST_MODE_ONEHOT: assert property ($onehot(power_mode))
    else $error("power mode not one-hot");
  AST_UNMAPPED: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
    else $error("unmapped access without slave error");
  AST_READY: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
endmodule // lvpw_props

bind lvpw_top lvpw_props i_props (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
  .supply_below_por, .supply_below_low, .system_reset, .detector_on, .irq, .power_mode);
`default_nettype wire

// *** testbench/lvpw_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module lvpw_top_test;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} lvpw_row_t;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, q;
  logic err = 1'h0;
  logic supply_below_por = 1'h1, supply_below_low = 1'h1, supply_below_high = 1'h1;
  logic warn_below_low = 1'h0, warn_below_high = 1'h0, wake_request = 1'h0;
  logic ext_reference_clock = 1'h0, internal_timer_clock = 1'h0;
  wire [31:0] prdata;
  wire pready, pslverr, system_reset, detector_on, irq;
  wire [4:0] power_mode;
  int fail_count = 0, total_checks = 0;
  // Write a word, read it back: address, data written, data expected.
  lvpw_row_t rows [7] = '{'{8'h00, 32'hFFFFFFFF, 32'h3F}, '{8'h04, 32'hFFFFFFFF, 32'h03},
    '{8'h08, 32'hFFFFFFFF, 32'h37}, '{8'h14, 32'hFFFFFFFF, 32'h03}, '{8'h0C, 32'hFFFFFFFF, 32'h03},
    '{8'h1C, 32'hFFFFFFFF, 32'h00}, '{8'h18, 32'h0, 32'h20}};

  lvpw_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .supply_below_por, .supply_below_low, .supply_below_high, .warn_below_low,
    .warn_below_high, .ext_reference_clock, .internal_timer_clock, .wake_request, .system_reset,
    .detector_on, .irq, .power_mode);

  // Free-running bus clock.
  always #5 pclk = ~pclk;

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // One APB transfer; an idle edge follows so the next setup never collides with this release.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // Only pready ends this wait, or the watchdog if it never rises; the master assumes no wait-state count.
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task rd(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(n, e, q);
  endtask

  // Timer source ticks are slow pulses, two bus cycles high and two low, so edge capture sees each.
  task tick(input logic s, input int n);
    repeat (n) begin
      if (s) internal_timer_clock <= 1'h1;
      else ext_reference_clock <= 1'h1;
      cyc(2);
      internal_timer_clock <= 1'h0;
      ext_reference_clock <= 1'h0;
      cyc(2);
    end
  endtask

  task done(input string s);
    $display("Test %s finished", s);
  endtask

  task close_out;
    $display("Checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Cuts a hang short; the whole run needs far fewer cycles than this.
  initial begin
    #200us;
    fail_count++;
    close_out();
  end

  // Main sequence.
  initial begin
    cyc(12);
    presetn <= 1'h1;
    cyc(3);
    chk("por_hold", 1, system_reset);
    supply_below_por <= 1'h0;
    cyc(3);
    chk("low_hold", 1, system_reset);
    supply_below_low <= 1'h0;
    supply_below_high <= 1'h0;
    cyc(3);
    chk("released", 0, system_reset);
    rd("cause", 8'h0C, 32'h3);
    rd("pwr_a_reset", 8'h00, 32'h5);
    done("power_on");
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].d);
      rd("row", rows[k].a, rows[k].e);
    end
    // The error answer is looked at in the access cycle, where it stands.
    apb(1'h0, 8'h1C, 32'h0);
    chk("slverr", 32'h1, err);
    apb(1'h0, 8'h18, 32'h0);
    chk("no_slverr", 32'h0, err);
    wr(8'h00, 32'h08);
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h14, 32'h1);
    supply_below_high <= 1'h1;
    cyc(4);
    chk("det_off", 0, irq);
    wr(8'h00, 32'h09);
    chk("det_on", 1, detector_on);
    chk("low_trip", 0, irq);
    wr(8'h04, 32'h1);
    // The flag is set one edge after the trip select lands.
    cyc(1);
    chk("high_trip", 1, irq);
    rd("stat", 8'h10, 32'h1);
    supply_below_high <= 1'h0;
    wr(8'h10, 32'h1);
    chk("lowv_clr", 0, irq);
    done("lowv_irq");
    warn_below_low <= 1'h1;
    cyc(3);
    rd("warn", 8'h04, 32'h81);
    chk("warn_irq", 0, irq);
    warn_below_low <= 1'h0;
    wr(8'h04, 32'h41);
    warn_below_high <= 1'h1;
    cyc(3);
    rd("warn_sel", 8'h04, 32'h01);
    warn_below_high <= 1'h0;
    done("warning");
    wr(8'h14, 32'h2);
    wr(8'h08, 32'h11);
    tick(0, 7);
    chk("tmr7", 0, irq);
    tick(0, 1);
    chk("tmr8", 1, irq);
    rd("tflag", 8'h08, 32'h91);
    wr(8'h14, 32'h0);
    chk("masked", 0, irq);
    wr(8'h10, 32'h2);
    wr(8'h14, 32'h2);
    rd("w1c", 8'h08, 32'h11);
    wr(8'h08, 32'h01);
    tick(0, 8);
    rd("no_ie", 8'h08, 32'h81);
    chk("no_ie_irq", 0, irq);
    wr(8'h08, 32'h41);
    rd("ack", 8'h08, 32'h01);
    wr(8'h08, 32'h0);
    tick(0, 16);
    rd("off", 8'h08, 32'h0);
    chk("off_irq", 0, irq);
    done("timer");
    wr(8'h00, 32'h03);
    wr(8'h18, 32'h2);
    rd("stop1_ref", 8'h18, 32'h30);
    wr(8'h18, 32'h3);
    rd("stop2_ref", 8'h18, 32'h30);
    wr(8'h00, 32'h01);
    wr(8'h08, 32'h11);
    wr(8'h18, 32'h3);
    chk("stop2", 5'h08, power_mode);
    chk("stop2_det", 0, detector_on);
    tick(0, 8);
    chk("stop2_ext", 5'h08, power_mode);
    tick(1, 8);
    cyc(2);
    chk("stop2_int", 5'h01, power_mode);
    wr(8'h10, 32'h2);
    wr(8'h00, 32'h0);
    wr(8'h18, 32'h2);
    tick(1, 8);
    tick(0, 8);
    chk("stop1", 5'h04, power_mode);
    wake_request <= 1'h1;
    cyc(2);
    wake_request <= 1'h0;
    chk("wake", 5'h01, power_mode);
    wr(8'h00, 32'h13);
    wr(8'h08, 32'h31);
    wr(8'h18, 32'h4);
    chk("stop3", 5'h10, power_mode);
    chk("stop3_det", 1, detector_on);
    tick(0, 8);
    chk("stop3_ext", 5'h10, power_mode);
    tick(1, 8);
    cyc(2);
    chk("stop3_int", 5'h01, power_mode);
    wr(8'h08, 32'h40);
    // Stop3 on the external source, with the oscillator kept on in stop and low range.
    wr(8'h08, 32'h11);
    wr(8'h18, 32'h4);
    tick(0, 8);
    cyc(2);
    chk("stop3_ext_src", 5'h01, power_mode);
    wr(8'h08, 32'h40);
    done("modes");
    wr(8'h00, 32'h05);
    // A supply below the low trip is below the high trip as well.
    supply_below_low <= 1'h1;
    supply_below_high <= 1'h1;
    cyc(3);
    chk("lv_rst", 1, system_reset);
    chk("lv_irq", 0, irq);
    cyc(5);
    chk("lv_hold", 1, system_reset);
    supply_below_low <= 1'h0;
    supply_below_high <= 1'h0;
    cyc(3);
    chk("lv_exit", 0, system_reset);
    apb(1'h0, 8'h0C, 32'h0);
    chk("lv_cause", 32'h1, q & 32'h1);
    rd("lv_def", 8'h00, 32'h5);
    done("lowv_reset");
    close_out();
  end
endmodule // lvpw_top_test
`default_nettype wire
